// File: logic/rscc_core.sv
// serial command core: spi slave, register file, payload fifos, modes
module rscc_core (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic chip_enable_pin,
  output logic interrupt_pin_n,
  output rscc_pkg::rscc_mode_t mode,
  output logic power_on,
  output logic receive_role,
  output logic features_on,
  input wire logic tx_done_pulse,
  input wire logic retry_fail_pulse,
  input wire logic [4:0] tx_rd_index,
  output logic [7:0] tx_rd_data,
  output logic tx_fifo_empty,
  output logic tx_reuse,
  output logic [9:0] tx_ctrl_field,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic rx_byte_last,
  output logic rx_byte_ready
);
  // ---------------- shared storage (sys domain) ----------------
  logic [7:0] regs_q [rscc_pkg::REG_COUNT][rscc_pkg::REG_BYTES];
  logic [7:0] tx_mem [rscc_pkg::FIFO_DEPTH][rscc_pkg::PAYLOAD_MAX];
  logic [7:0] rx_mem [rscc_pkg::FIFO_DEPTH][rscc_pkg::PAYLOAD_MAX];
  logic [5:0] tx_len_q [rscc_pkg::FIFO_DEPTH];
  logic tx_noack_q [rscc_pkg::FIFO_DEPTH];
  logic [5:0] rx_len_q [rscc_pkg::FIFO_DEPTH];
  logic [1:0] tx_head_q, tx_tail_q, tx_cnt_q;
  logic [1:0] rx_head_q, rx_tail_q, rx_cnt_q;
  logic [7:0] status_pub_q, fifo_pub_q;
  logic feat_q, reuse_q;
  logic [2:0] flags_q;

  // ---------------- link domain (spi_clk) ----------------
  logic link_rst_n;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [5:0] byte_q, idx_q;
  logic [7:0] cmd_q, data_q, tx_q, reply;
  logic tgl_q, first_q;
  logic [5:0] d_idx;

  // frame state is cleared by select going high, so no sck edge is needed
  assign link_rst_n = rstn & ~chip_select_n;

  always_ff @(posedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      byte_q <= 6'h00;
      cmd_q <= rscc_pkg::CMD_IDLE;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q <= {sh_q[5:0], spi_mosi};
      if (bit_q == 3'h7) begin
        if (byte_q == 6'h00) begin
          cmd_q <= {sh_q, spi_mosi};
        end
        if (byte_q != 6'h3F) begin
          byte_q <= byte_q + 6'h01;
        end
      end
    end
  end

  // handoff survives frames: resetting the toggle per frame would fake a byte
  always_ff @(posedge spi_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= 8'h00;
      idx_q <= 6'h00;
      tgl_q <= 1'b0;
    end else if (!chip_select_n && bit_q == 3'h7) begin
      data_q <= {sh_q, spi_mosi};
      idx_q <= byte_q;
      tgl_q <= ~tgl_q;
    end
  end

  assign d_idx = byte_q - 6'h01;

  // sys-side sources are frozen while a frame is open, so sampling them
  // here is safe; the reply must be ready half an sck period after a byte
  always_comb begin
    reply = 8'h00;
    if (cmd_q[7:5] == rscc_pkg::OP_RD_REG) begin
      if (cmd_q[4:0] == rscc_pkg::ADDR_STATUS) begin
        reply = status_pub_q;
      end else if (cmd_q[4:0] == rscc_pkg::ADDR_FIFO) begin
        reply = fifo_pub_q;
      end else if (d_idx < 6'(rscc_pkg::REG_BYTES)) begin
        reply = regs_q[cmd_q[4:0]][d_idx[2:0]];
      end
    end else if (cmd_q == rscc_pkg::CMD_RD_PAYLOAD) begin
      if (d_idx < 6'(rscc_pkg::PAYLOAD_MAX)) begin
        reply = rx_mem[rx_head_q][d_idx[4:0]];
      end
    end else if (cmd_q == rscc_pkg::CMD_LEN_QUERY) begin
      if (feat_q && d_idx == 6'h00) begin
        reply = {2'h0, rx_len_q[rx_head_q]};
      end
    end
  end

  always_ff @(negedge spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_q <= 8'h00;
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
      if (byte_q == 6'h00 && bit_q == 3'h1) begin
        tx_q <= {status_pub_q[6:0], 1'b0};
      end else if (byte_q != 6'h00 && bit_q == 3'h0) begin
        tx_q <= reply;
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // status msb must be valid before the first sck edge of the frame
  assign spi_miso = first_q ? status_pub_q[7] : tx_q[7];
  assign spi_miso_oe = ~chip_select_n;

  // ---------------- crossings into sys domain ----------------
  logic tgl_s1, tgl_s2, tgl_s3;
  logic csn_s1, csn_s2, csn_s3, csn_s4;
  logic ce_s1, ce_s2;
  logic byte_ev, frame_end;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
      csn_s3 <= 1'b1;
      csn_s4 <= 1'b1;
      ce_s1 <= 1'b0;
      ce_s2 <= 1'b0;
    end else if (clk_en) begin
      tgl_s1 <= tgl_q;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      csn_s1 <= chip_select_n;
      csn_s2 <= csn_s1;
      csn_s3 <= csn_s2;
      csn_s4 <= csn_s3;
      ce_s1 <= chip_enable_pin;
      ce_s2 <= ce_s1;
    end
  end

  assign byte_ev = clk_en && (tgl_s2 ^ tgl_s3);
  // one extra stage so the last byte is always handled before the end
  assign frame_end = clk_en && csn_s3 && !csn_s4;

  // ---------------- command execution ----------------
  logic [7:0] scmd_q;
  logic [5:0] sdcnt_q, wb;
  logic is_wr_reg, is_load, is_load_any;
  logic flush_tx, flush_rx, tx_push, tx_pop, rx_pop, rx_push;
  logic [2:0] clr_flags, set_flags;
  logic [7:0] cfg;

  assign wb = idx_q - 6'h01;
  assign cfg = regs_q[rscc_pkg::ADDR_CONFIG][0];
  assign is_wr_reg = scmd_q[7:5] == rscc_pkg::OP_WR_REG;
  assign is_load = scmd_q == rscc_pkg::CMD_LOAD_TX;
  assign is_load_any = is_load ||
    (feat_q && scmd_q == rscc_pkg::CMD_LOAD_UNACKED);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scmd_q <= rscc_pkg::CMD_IDLE;
      sdcnt_q <= 6'h00;
    end else if (clk_en) begin
      if (byte_ev) begin
        if (idx_q == 6'h00) begin
          scmd_q <= data_q;
        end
        sdcnt_q <= idx_q;
      end else if (frame_end) begin
        scmd_q <= rscc_pkg::CMD_IDLE;
        sdcnt_q <= 6'h00;
      end
    end
  end

  assign flush_tx = byte_ev && idx_q == 6'h00 &&
    data_q == rscc_pkg::CMD_FLUSH_TX;
  assign flush_rx = byte_ev && idx_q == 6'h00 &&
    data_q == rscc_pkg::CMD_FLUSH_RX;
  assign tx_push = frame_end && is_load_any && sdcnt_q != 6'h00 &&
    tx_cnt_q != rscc_pkg::CNT_FULL;
  // a retry failure never pops: the packet waits for resend or flush
  assign tx_pop = clk_en && tx_done_pulse && !reuse_q &&
    tx_cnt_q != 2'h0;
  assign rx_pop = frame_end && scmd_q == rscc_pkg::CMD_RD_PAYLOAD &&
    sdcnt_q != 6'h00 && rx_cnt_q != 2'h0;
  assign rx_byte_ready = rx_cnt_q != rscc_pkg::CNT_FULL;

  // register file; a short write leaves the upper bytes alone
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < rscc_pkg::REG_COUNT; a++) begin
        for (int b = 0; b < rscc_pkg::REG_BYTES; b++) begin
          regs_q[a][b] <= rscc_pkg::REG_RESET;
        end
      end
    end else if (clk_en && byte_ev && is_wr_reg && idx_q != 6'h00 &&
                 idx_q <= 6'(rscc_pkg::REG_BYTES)) begin
      if (scmd_q[4:0] != rscc_pkg::ADDR_STATUS &&
          scmd_q[4:0] != rscc_pkg::ADDR_FIFO) begin
        regs_q[scmd_q[4:0]][wb[2:0]] <= data_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      feat_q <= 1'b0;
    end else if (clk_en && byte_ev && idx_q == 6'h01 &&
                 scmd_q == rscc_pkg::CMD_FEATURE &&
                 data_q == rscc_pkg::FEATURE_KEY) begin
      feat_q <= ~feat_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reuse_q <= 1'b0;
    end else if (clk_en) begin
      if (flush_tx || tx_push) begin
        reuse_q <= 1'b0;
      end else if (byte_ev && idx_q == 6'h00 &&
                   data_q == rscc_pkg::CMD_REPEAT) begin
        reuse_q <= 1'b1;
      end
    end
  end

  // ---------------- flags ----------------
  assign clr_flags = (byte_ev && is_wr_reg && idx_q == 6'h01 &&
    scmd_q[4:0] == rscc_pkg::ADDR_STATUS) ?
    data_q[rscc_pkg::ST_FLAG_LSB +: 3] : 3'h0;
  assign set_flags = {rx_push && rx_byte_last, tx_done_pulse,
    retry_fail_pulse};

  // a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= 3'h0;
    end else if (clk_en) begin
      flags_q <= (flags_q & ~clr_flags) | set_flags;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_pin_n <= 1'b1;
    end else if (clk_en) begin
      interrupt_pin_n <=
        ~|(flags_q & ~cfg[rscc_pkg::CFG_MASK_LSB +: 3]);
    end
  end

  // published copies only move while select is high
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_pub_q <= 8'h00;
      fifo_pub_q <= 8'h00;
    end else if (clk_en && csn_s2) begin
      status_pub_q <= {1'b0, flags_q, 3'h0,
        tx_cnt_q == rscc_pkg::CNT_FULL};
      fifo_pub_q <= {1'b0, reuse_q, tx_cnt_q == rscc_pkg::CNT_FULL,
        tx_cnt_q == 2'h0, 2'h0, rx_cnt_q == rscc_pkg::CNT_FULL,
        rx_cnt_q == 2'h0};
    end
  end

  // ---------------- tx fifo ----------------
  always_ff @(posedge sys_clk) begin
    if (clk_en && byte_ev && is_load_any && idx_q != 6'h00 &&
        idx_q <= 6'(rscc_pkg::PAYLOAD_MAX) &&
        tx_cnt_q != rscc_pkg::CNT_FULL) begin
      tx_mem[tx_tail_q][wb[4:0]] <= data_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_head_q <= 2'h0;
      tx_tail_q <= 2'h0;
      tx_cnt_q <= 2'h0;
      for (int i = 0; i < rscc_pkg::FIFO_DEPTH; i++) begin
        tx_len_q[i] <= 6'h00;
        tx_noack_q[i] <= 1'b0;
      end
    end else if (clk_en) begin
      if (flush_tx) begin
        tx_head_q <= 2'h0;
        tx_tail_q <= 2'h0;
        tx_cnt_q <= 2'h0;
      end else begin
        if (tx_push) begin
          tx_len_q[tx_tail_q] <= (sdcnt_q > 6'(rscc_pkg::PAYLOAD_MAX)) ?
            6'(rscc_pkg::PAYLOAD_MAX) : sdcnt_q;
          tx_noack_q[tx_tail_q] <= !is_load;
          tx_tail_q <= (tx_tail_q == rscc_pkg::PTR_LAST) ? 2'h0 :
            tx_tail_q + 2'h1;
        end
        if (tx_pop) begin
          tx_head_q <= (tx_head_q == rscc_pkg::PTR_LAST) ? 2'h0 :
            tx_head_q + 2'h1;
        end
        if (tx_push && !tx_pop) begin
          tx_cnt_q <= tx_cnt_q + 2'h1;
        end else if (tx_pop && !tx_push) begin
          tx_cnt_q <= tx_cnt_q - 2'h1;
        end
      end
    end
  end

  // sequence id advances per fresh packet, held while repeating
  logic [1:0] seq_id_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seq_id_q <= 2'h0;
    end else if (tx_pop) begin
      seq_id_q <= seq_id_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_rd_data <= 8'h00;
      tx_ctrl_field <= 10'h000;
    end else if (clk_en) begin
      tx_rd_data <= tx_mem[tx_head_q][tx_rd_index];
      tx_ctrl_field <= {1'b0, tx_len_q[tx_head_q], seq_id_q,
        tx_noack_q[tx_head_q]};
    end
  end

  assign tx_fifo_empty = tx_cnt_q == 2'h0;
  assign tx_reuse = reuse_q;

  // ---------------- rx fifo ----------------
  logic [5:0] rx_wcnt_q;
  assign rx_push = clk_en && rx_byte_valid && rx_byte_ready;

  always_ff @(posedge sys_clk) begin
    if (rx_push && rx_wcnt_q < 6'(rscc_pkg::PAYLOAD_MAX)) begin
      rx_mem[rx_tail_q][rx_wcnt_q[4:0]] <= rx_byte_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_head_q <= 2'h0;
      rx_tail_q <= 2'h0;
      rx_cnt_q <= 2'h0;
      rx_wcnt_q <= 6'h00;
      for (int i = 0; i < rscc_pkg::FIFO_DEPTH; i++) begin
        rx_len_q[i] <= 6'h00;
      end
    end else if (clk_en) begin
      if (flush_rx) begin
        rx_head_q <= 2'h0;
        rx_tail_q <= 2'h0;
        rx_cnt_q <= 2'h0;
        rx_wcnt_q <= 6'h00;
      end else begin
        if (rx_push && rx_byte_last) begin
          rx_len_q[rx_tail_q] <= (rx_wcnt_q < 6'(rscc_pkg::PAYLOAD_MAX)) ?
            rx_wcnt_q + 6'h01 : 6'(rscc_pkg::PAYLOAD_MAX);
          rx_tail_q <= (rx_tail_q == rscc_pkg::PTR_LAST) ? 2'h0 :
            rx_tail_q + 2'h1;
          rx_wcnt_q <= 6'h00;
        end else if (rx_push && rx_wcnt_q < 6'(rscc_pkg::PAYLOAD_MAX)) begin
          rx_wcnt_q <= rx_wcnt_q + 6'h01;
        end
        if (rx_pop) begin
          rx_head_q <= (rx_head_q == rscc_pkg::PTR_LAST) ? 2'h0 :
            rx_head_q + 2'h1;
        end
        if (rx_push && rx_byte_last && !rx_pop) begin
          rx_cnt_q <= rx_cnt_q + 2'h1;
        end else if (rx_pop && !(rx_push && rx_byte_last)) begin
          rx_cnt_q <= rx_cnt_q - 2'h1;
        end
      end
    end
  end

  // ---------------- mode ----------------
  rscc_pkg::rscc_mode_t mode_d;
  always_comb begin
    if (!cfg[rscc_pkg::CFG_POWER_BIT]) begin
      mode_d = rscc_pkg::MODE_SLEEP;
    end else if (!ce_s2) begin
      mode_d = rscc_pkg::MODE_STANDBY_ONE;
    end else if (cfg[rscc_pkg::CFG_ROLE_BIT]) begin
      mode_d = rscc_pkg::MODE_RECEIVE;
    end else if (tx_cnt_q != 2'h0) begin
      mode_d = rscc_pkg::MODE_TRANSMIT;
    end else begin
      mode_d = rscc_pkg::MODE_STANDBY_TWO;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode <= rscc_pkg::MODE_SLEEP;
    end else if (clk_en) begin
      mode <= mode_d;
    end
  end

  assign power_on = cfg[rscc_pkg::CFG_POWER_BIT];
  assign receive_role = cfg[rscc_pkg::CFG_ROLE_BIT];
  assign features_on = feat_q;
endmodule

// File: inc/rscc_pkg.sv
// constants and types shared by the radio serial command core
package rscc_pkg;
  // command words
  localparam logic [7:0] CMD_RD_PAYLOAD = 8'h61;
  localparam logic [7:0] CMD_LEN_QUERY = 8'h60;
  localparam logic [7:0] CMD_LOAD_TX = 8'hA0;
  localparam logic [7:0] CMD_LOAD_UNACKED = 8'hB0;
  localparam logic [7:0] CMD_FLUSH_TX = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX = 8'hE2;
  localparam logic [7:0] CMD_REPEAT = 8'hE3;
  localparam logic [7:0] CMD_FEATURE = 8'h50;
  localparam logic [7:0] CMD_IDLE = 8'hFF;
  localparam logic [7:0] FEATURE_KEY = 8'h73;
  localparam logic [2:0] OP_RD_REG = 3'h0;
  localparam logic [2:0] OP_WR_REG = 3'h1;

  // register map
  localparam int REG_COUNT = 32;
  localparam int REG_BYTES = 5;
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h07;
  localparam logic [4:0] ADDR_FIFO = 5'h17;
  localparam logic [7:0] REG_RESET = 8'h00;

  // config byte fields
  localparam int CFG_ROLE_BIT = 0;
  localparam int CFG_POWER_BIT = 1;
  localparam int CFG_MASK_LSB = 4;
  // status byte fields: flags sit at [6:4] as {rx, tx, retry}
  localparam int ST_TX_FULL_BIT = 0;
  localparam int ST_FLAG_LSB = 4;
  localparam int FLAG_RETRY = 0;
  localparam int FLAG_TX = 1;
  localparam int FLAG_RX = 2;
  // fifo status byte fields
  localparam int FS_RX_EMPTY = 0;
  localparam int FS_RX_FULL = 1;
  localparam int FS_TX_EMPTY = 4;
  localparam int FS_TX_FULL = 5;
  localparam int FS_REUSE = 6;

  // payload storage
  localparam int PAYLOAD_MAX = 32;
  localparam int FIFO_DEPTH = 3;
  localparam logic [1:0] PTR_LAST = 2'h2;
  localparam logic [1:0] CNT_FULL = 2'h3;

  // on-air layout
  localparam int PREAMBLE_BYTES = 3;
  localparam int ADDR_MIN_BYTES = 3;
  localparam int ADDR_MAX_BYTES = 5;
  localparam int CRC_BYTES = 2;
  localparam int CTRL_LEN_BITS = 7;
  localparam int CTRL_PID_BITS = 2;
  localparam int CTRL_NOACK_BITS = 1;
  localparam int CTRL_BITS = CTRL_LEN_BITS + CTRL_PID_BITS + CTRL_NOACK_BITS;

  typedef enum logic [2:0] {
    MODE_SLEEP,
    MODE_STANDBY_ONE,
    MODE_STANDBY_TWO,
    MODE_RECEIVE,
    MODE_TRANSMIT
  } rscc_mode_t;
endpackage

// File: dv/rscc_core_asserts.sv
// port assertions for the radio serial command core
module rscc_core_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic chip_select_n,
  input wire logic spi_miso_oe,
  input wire logic chip_enable_pin,
  input wire logic interrupt_pin_n,
  input rscc_pkg::rscc_mode_t mode,
  input wire logic power_on,
  input wire logic receive_role,
  input wire logic tx_done_pulse,
  input wire logic retry_fail_pulse,
  input wire logic tx_fifo_empty,
  input wire logic tx_reuse,
  input wire logic rx_byte_valid,
  input wire logic rx_byte_last
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  logic [15:0] evt_q;

  // 16 cycles covers the enable sync plus the unmasking write landing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_q <= '0;
    end else begin
      evt_q <= {evt_q[14:0], tx_done_pulse | retry_fail_pulse |
        (rx_byte_valid & rx_byte_last) | ~chip_select_n};
    end
  end

  sequence s_rx_req;
    (power_on && receive_role && chip_enable_pin) [*5];
  endsequence
  sequence s_parked;
    (power_on && !chip_enable_pin) [*5];
  endsequence
  sequence s_tx_req;
    (power_on && !receive_role && chip_enable_pin && !tx_fifo_empty) [*5];
  endsequence
  sequence s_tx_none;
    (power_on && !receive_role && chip_enable_pin && tx_fifo_empty) [*5];
  endsequence

  AST_MODE_OFF: assert property (
    (!power_on) [*3] |-> mode == rscc_pkg::MODE_SLEEP)
    else $error("mode not sleep while power is off");
  AST_MODE_RX: assert property (
    s_rx_req |-> mode == rscc_pkg::MODE_RECEIVE)
    else $error("mode not receive");
  AST_MODE_SB1: assert property (
    s_parked |-> mode == rscc_pkg::MODE_STANDBY_ONE)
    else $error("mode not first standby");
  AST_MODE_TX: assert property (
    s_tx_req |-> mode == rscc_pkg::MODE_TRANSMIT)
    else $error("mode not transmit");
  AST_MODE_SB2: assert property (
    s_tx_none |-> mode == rscc_pkg::MODE_STANDBY_TWO)
    else $error("mode not second standby");
  AST_RESET_STATE: assert property (
    $rose(rstn) |-> mode == rscc_pkg::MODE_SLEEP && interrupt_pin_n
    && tx_fifo_empty)
    else $error("state after reset wrong");
  AST_MISO_DRIVE: assert property (
    spi_miso_oe == !chip_select_n)
    else $error("miso driven outside the frame");
  AST_IRQ_CAUSE: assert property (
    $fell(interrupt_pin_n) |-> evt_q != 16'h0000)
    else $error("interrupt pin fell with no cause");
  AST_RETRY_KEEP: assert property (
    retry_fail_pulse && !tx_fifo_empty |=> !tx_fifo_empty [*2])
    else $error("packet dropped at retry limit");
  AST_REUSE_KEEP: assert property (
    tx_done_pulse && tx_reuse && !tx_fifo_empty |=> !tx_fifo_empty)
    else $error("repeated packet dropped after send");
endmodule

bind rscc_core rscc_core_asserts chk_u (.sys_clk, .rstn, .chip_select_n,
  .spi_miso_oe, .chip_enable_pin, .interrupt_pin_n, .mode, .power_on,
  .receive_role, .tx_done_pulse, .retry_fail_pulse, .tx_fifo_empty,
  .tx_reuse, .rx_byte_valid, .rx_byte_last);

// File: dv/rscc_host_model.sv
// host serial master model driving the core's serial port
module rscc_host_model (
  output logic spi_clk,
  output logic chip_select_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_buf [8];
  logic [7:0] rx_buf [8];

  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // clock idle low, stands still outside frames
  task automatic run(input int n);
    chip_select_n = 1'b0; // one command per low period
    #37;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        spi_mosi = tx_buf[b][i]; // msb first, change on fall
        #32 spi_clk = 1'b1;
        rx_buf[b][i] = spi_miso; // sample on rise
        #32 spi_clk = 1'b0;
      end
      // released line shows the inverse, not a stale bit
      spi_mosi = ~spi_mosi;
      #512; // keeps each byte at least 1 us apart
    end
    #64 chip_select_n = 1'b1;
    #300; // select high well over 240 ns between frames
  endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the radio serial command core
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rstn, clk_en, spi_clk, chip_select_n, spi_mosi;
  logic spi_miso, spi_miso_oe, chip_enable_pin, interrupt_pin_n;
  logic power_on, receive_role, features_on, tx_done_pulse;
  logic retry_fail_pulse, tx_fifo_empty, tx_reuse;
  logic rx_byte_valid, rx_byte_last, rx_byte_ready;
  logic [4:0] tx_rd_index;
  logic [7:0] tx_rd_data, rx_byte_data;
  logic [9:0] tx_ctrl_field;
  rscc_pkg::rscc_mode_t mode;
  int n_fail, comparisons;

  rscc_core dut_u (.sys_clk, .rstn, .clk_en, .spi_clk, .chip_select_n,
    .spi_mosi, .spi_miso, .spi_miso_oe, .chip_enable_pin, .interrupt_pin_n,
    .mode, .power_on, .receive_role, .features_on, .tx_done_pulse,
    .retry_fail_pulse, .tx_rd_index, .tx_rd_data, .tx_fifo_empty,
    .tx_reuse, .tx_ctrl_field, .rx_byte_valid, .rx_byte_data,
    .rx_byte_last, .rx_byte_ready);
  rscc_host_model host_u (.spi_clk, .chip_select_n, .spi_mosi, .spi_miso);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic [39:0] d, input int n);
    host_u.tx_buf[0] = c;
    for (int i = 0; i < n; i++)
      host_u.tx_buf[i+1] = d[8*i +: 8];
    @(negedge sys_clk);
    host_u.run(n + 1);
    // frames end off the grid; realign so later strobes span a rising edge
    @(negedge sys_clk);
  endtask

  function automatic logic [39:0] got(input int n);
    logic [39:0] v;
    v = '0;
    for (int i = 0; i < n; i++)
      v[8*i +: 8] = host_u.rx_buf[i+1];
    return v;
  endfunction

  task automatic cfg(input logic [7:0] v);
    wr({rscc_pkg::OP_WR_REG, rscc_pkg::ADDR_CONFIG}, 40'(v), 1);
  endtask

  task automatic status(input logic [7:0] exp);
    wr(rscc_pkg::CMD_IDLE, '0, 0);
    cmp(host_u.rx_buf[0], exp);
  endtask

  task automatic wait_mode(input rscc_pkg::rscc_mode_t m);
    for (int i = 0; i < 20 && mode !== m; i++)
      @(negedge sys_clk);
    cmp(mode, m);
    if (mode !== m)
      print_verdict();
  endtask

  task automatic pulse(input bit retry);
    if (retry)
      retry_fail_pulse = 1'b1;
    else
      tx_done_pulse = 1'b1;
    @(negedge sys_clk);
    tx_done_pulse = 1'b0;
    retry_fail_pulse = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic push(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid = 1'b1;
      rx_byte_data = b + 8'(i);
      rx_byte_last = (i == n - 1);
      @(negedge sys_clk);
    end
    rx_byte_valid = 1'b0;
    rx_byte_last = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic t_reset;
    cmp(mode, rscc_pkg::MODE_SLEEP);
    cmp({interrupt_pin_n, tx_fifo_empty, rx_byte_ready}, 3'h7);
    status(8'h00);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr({rscc_pkg::OP_WR_REG, 5'h05}, 40'h55_4433_2211, 5);
    wr({rscc_pkg::OP_RD_REG, 5'h05}, '1, 5);
    cmp(got(5), 40'h55_4433_2211);
    wr({rscc_pkg::OP_WR_REG, 5'h05}, 40'hab, 1);
    wr({rscc_pkg::OP_RD_REG, 5'h05}, '1, 5);
    cmp(got(5), 40'h55_4433_22ab);
    $display("test registers done");
  endtask

  task automatic t_modes;
    cfg(8'h03);
    chip_enable_pin = 1'b1;
    wait_mode(rscc_pkg::MODE_RECEIVE);
    cmp({power_on, receive_role}, 2'h3);
    chip_enable_pin = 1'b0;
    wait_mode(rscc_pkg::MODE_STANDBY_ONE);
    cfg(8'h02);
    chip_enable_pin = 1'b1;
    wait_mode(rscc_pkg::MODE_STANDBY_TWO);
    wr(rscc_pkg::CMD_LOAD_TX, 40'hc35a, 2);
    wait_mode(rscc_pkg::MODE_TRANSMIT);
    tx_rd_index = 5'h01;
    repeat (2) @(negedge sys_clk);
    cmp(tx_rd_data, 8'hc3);
    tx_rd_index = 5'h00;
    repeat (2) @(negedge sys_clk);
    cmp(tx_rd_data, 8'h5a);
    wr(rscc_pkg::CMD_FLUSH_TX, '0, 0);
    wait_mode(rscc_pkg::MODE_STANDBY_TWO);
    chip_enable_pin = 1'b0;
    cfg(8'h00);
    wait_mode(rscc_pkg::MODE_SLEEP);
    $display("test modes done");
  endtask

  task automatic t_irq;
    wr(rscc_pkg::CMD_LOAD_TX, 40'h11, 1);
    pulse(1'b0);
    cmp(interrupt_pin_n, 1'b0);
    status(8'h20);
    wr({rscc_pkg::OP_WR_REG, rscc_pkg::ADDR_STATUS}, 40'h00, 1);
    cmp(interrupt_pin_n, 1'b0);
    wr({rscc_pkg::OP_WR_REG, rscc_pkg::ADDR_STATUS}, 40'h20, 1);
    cmp(interrupt_pin_n, 1'b1);
    cfg(8'h20);
    pulse(1'b0);
    cmp(interrupt_pin_n, 1'b1);
    status(8'h20);
    wr(rscc_pkg::CMD_LOAD_TX, 40'h22, 1);
    pulse(1'b1);
    cmp(tx_fifo_empty, 1'b0);
    cmp(interrupt_pin_n, 1'b0);
    status(8'h30);
    wr({rscc_pkg::OP_WR_REG, rscc_pkg::ADDR_STATUS}, 40'h70, 1);
    cfg(8'h00);
    wr(rscc_pkg::CMD_FLUSH_TX, '0, 0);
    $display("test interrupt done");
  endtask

  task automatic t_rx;
    push(3, 8'h40);
    wr(rscc_pkg::CMD_FEATURE, 40'(rscc_pkg::FEATURE_KEY), 1);
    cmp(features_on, 1'b1);
    wr(rscc_pkg::CMD_LEN_QUERY, '1, 1);
    cmp(host_u.rx_buf[1], 8'h03);
    wr(rscc_pkg::CMD_RD_PAYLOAD, '1, 3);
    cmp(got(3), 40'h42_4140);
    wr({rscc_pkg::OP_RD_REG, rscc_pkg::ADDR_FIFO}, '1, 1);
    cmp(host_u.rx_buf[1][0], 1'b1);
    push(2, 8'h50);
    wr(rscc_pkg::CMD_FLUSH_RX, '0, 0);
    wr({rscc_pkg::OP_RD_REG, rscc_pkg::ADDR_FIFO}, '1, 1);
    cmp(host_u.rx_buf[1][0], 1'b1);
    wr(rscc_pkg::CMD_FEATURE, 40'(rscc_pkg::FEATURE_KEY), 1);
    cmp(features_on, 1'b0);
    wr({rscc_pkg::OP_WR_REG, rscc_pkg::ADDR_STATUS}, 40'h70, 1);
    // a frozen core must not record an event
    clk_en = 1'b0;
    pulse(1'b1);
    clk_en = 1'b1;
    status(8'h00);
    $display("test receive done");
  endtask

  task automatic t_repeat;
    wr(rscc_pkg::CMD_LOAD_TX, 40'h77, 1);
    wr(rscc_pkg::CMD_REPEAT, '0, 0);
    cmp(tx_reuse, 1'b1);
    pulse(1'b0);
    cmp(tx_fifo_empty, 1'b0);
    wr(rscc_pkg::CMD_LOAD_TX, 40'h88, 1);
    cmp(tx_reuse, 1'b0);
    wr(rscc_pkg::CMD_FLUSH_TX, '0, 0);
    wr(rscc_pkg::CMD_FEATURE, 40'(rscc_pkg::FEATURE_KEY), 1);
    wr(rscc_pkg::CMD_LOAD_UNACKED, 40'h99, 1);
    cmp(tx_ctrl_field[0], 1'b1);
    cmp(tx_ctrl_field[9:3], 7'h01);
    cmp(tx_ctrl_field[2:1], 2'h1);
    wr(rscc_pkg::CMD_FLUSH_TX, '0, 0);
    wr(rscc_pkg::CMD_FEATURE, 40'(rscc_pkg::FEATURE_KEY), 1);
    wr({rscc_pkg::OP_WR_REG, rscc_pkg::ADDR_STATUS}, 40'h70, 1);
    $display("test repeat done");
  endtask

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    chip_enable_pin = 1'b0;
    tx_done_pulse = 1'b0;
    retry_fail_pulse = 1'b0;
    tx_rd_index = 5'h00;
    rx_byte_valid = 1'b0;
    rx_byte_data = 8'h00;
    rx_byte_last = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_regs();
    t_modes();
    t_irq();
    t_rx();
    t_repeat();
    print_verdict();
  end
endmodule
